// file: rtl/irq_logic_pkg.sv
// Package of register map, field positions and reset values
package irq_logic_pkg;
    // ------------------------------------------------------------------
    // Register byte addresses
    // ------------------------------------------------------------------
    localparam logic [3:0] ADDR_CORE_CTRL  = 4'h0;
    localparam logic [3:0] ADDR_PERIPH_ONE = 4'h4;
    localparam logic [3:0] ADDR_PERIPH_TWO = 4'h8;
    localparam logic [3:0] ADDR_PERIPH_FLG = 4'hC;
    // ------------------------------------------------------------------
    // Core control field positions
    // ------------------------------------------------------------------
    localparam int BIT_GLOBAL_EN  = 7;
    localparam int BIT_PERIPH_EN  = 6;
    localparam int BIT_T0_EN      = 5;
    localparam int BIT_EXT_EN     = 4;
    localparam int BIT_CHG_EN     = 3;
    localparam int BIT_T0_FLAG    = 2;
    localparam int BIT_EXT_FLAG   = 1;
    localparam int BIT_CHG_FLAG   = 0;
    // ------------------------------------------------------------------
    // Implemented bits, reset values and response codes
    // ------------------------------------------------------------------
    localparam logic [7:0] MASK_PERIPH_ONE = 8'h3F;
    localparam logic [7:0] MASK_PERIPH_TWO = 8'hDF;
    localparam logic [7:0] RST_CORE_CTRL   = 8'h00;
    localparam logic [7:0] RST_PERIPH      = 8'h00;
    localparam logic [1:0] RESP_OKAY       = 2'b00;
    localparam logic [1:0] RESP_SLVERR     = 2'b10;
endpackage

// file: rtl/irq_reg_if.sv
// Interface carrying register write strobes between modules
`timescale 1ns/10ps
interface irq_reg_if;
    logic       wr_en;
    logic [3:0] wr_addr;
    logic [7:0] wr_data;
    logic [7:0] peripheral_enable_one;
    logic [7:0] peripheral_enable_two;
    modport owner (
        input  wr_en,
        input  wr_addr,
        input  wr_data,
        output peripheral_enable_one,
        output peripheral_enable_two
    );
    modport user (
        output wr_en,
        output wr_addr,
        output wr_data,
        input  peripheral_enable_one,
        input  peripheral_enable_two
    );
endinterface

// file: rtl/periph_enable_regs.sv
// Peripheral enable registers with unimplemented bits held at zero
`timescale 1ns/10ps
module periph_enable_regs (
    input  wire logic sys_clk_i,
    input  wire logic arst_n_i,
    input  wire logic clk_en_i,
    irq_reg_if.owner  regs
);
    typedef struct packed {
        logic [7:0] one;
        logic [7:0] two;
    } pe_state_s;

    pe_state_s state_ff;
    pe_state_s nxt_state;

    always_comb begin
        nxt_state = state_ff;
        if (regs.wr_en && regs.wr_addr == irq_logic_pkg::ADDR_PERIPH_ONE)
        begin
            nxt_state.one = regs.wr_data
                          & irq_logic_pkg::MASK_PERIPH_ONE; // [RULE_16]
        end
        if (regs.wr_en && regs.wr_addr == irq_logic_pkg::ADDR_PERIPH_TWO)
        begin
            nxt_state.two = regs.wr_data
                          & irq_logic_pkg::MASK_PERIPH_TWO; // [RULE_16]
        end
    end

    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            state_ff <= '{one: irq_logic_pkg::RST_PERIPH,
                          two: irq_logic_pkg::RST_PERIPH};
        end else if (clk_en_i) begin
            state_ff <= nxt_state;
        end
    end

    assign regs.peripheral_enable_one = state_ff.one;
    assign regs.peripheral_enable_two = state_ff.two;
endmodule

// file: rtl/interrupt_enable_flag_logic.sv
// Interrupt enable, flag and request logic with AXI4-Lite registers
// Overview of operation
// RULE_01 - Flags set on source events regardless of any enable bit
// RULE_02 - Firmware clears stale flags before setting the matching enable
// RULE_03 - Global enable bit 7 allows unmasked interrupts, blocks all when 0
// RULE_04 - Bit 6 peripheral group enable gates all peripheral interrupts
// RULE_05 - Bit 5 enables timer-0 overflow interrupt
// RULE_06 - Bit 4 enables external pin interrupt
// RULE_07 - Bit 3 enables pin change; per-pin enables also needed
// RULE_08 - Bit 2 timer-0 flag set on rollover, held until written zero
// RULE_09 - Firmware loads timer 0 before clearing its overflow flag
// RULE_10 - Bit 1 external flag set on pin event, cleared by firmware only
// RULE_11 - Bit 0 pin-change flag on enabled pin change; reset value unknown (this design resets it to 0 with RST_CORE_CTRL)
// RULE_12 - Peripheral one bit 5 gates bus collision interrupt
// RULE_13 - Peripheral one bit 4 gates serial port interrupt
// RULE_14 - Peripheral one bits 3,2 gate capture/compare 2 and 1
// RULE_15 - Peripheral one bits 1,0 gate timer-2 match and timer-1 overflow
// RULE_16 - Unimplemented enable bits ignore writes and read zero
// RULE_17 - Peripheral two bit 7 gates desaturation detect interrupt
// RULE_18 - Peripheral two bit 6 gates ADC complete interrupt
// RULE_19 - Peripheral two bit 4 gates overtemperature interrupt
// RULE_20 - Peripheral two bit 3 gates output overvoltage interrupt
// RULE_21 - Peripheral two bit 2 gates gate-drive undervoltage interrupt
// RULE_22 - Peripheral two bits 1,0 gate input over/undervoltage lockout
// RULE_23 - Servicing clears global enable; core pushes and vectors
// RULE_24 - Request when global enable and any enabled flag pair set
//
// The AXI4-Lite register port and the address map are this design's own decisions.
`timescale 1ns/10ps
module interrupt_enable_flag_logic (
    input  wire logic        sys_clk_i,
    input  wire logic        arst_n_i,
    input  wire logic        clk_en_i,
    input  wire logic [3:0]  s_axi_awaddr_i,
    input  wire logic        s_axi_awvalid_i,
    output logic             s_axi_awready_o,
    input  wire logic [31:0] s_axi_wdata_i,
    input  wire logic [3:0]  s_axi_wstrb_i,
    input  wire logic        s_axi_wvalid_i,
    output logic             s_axi_wready_o,
    output logic [1:0]       s_axi_bresp_o,
    output logic             s_axi_bvalid_o,
    input  wire logic        s_axi_bready_i,
    input  wire logic [3:0]  s_axi_araddr_i,
    input  wire logic        s_axi_arvalid_i,
    output logic             s_axi_arready_o,
    output logic [31:0]      s_axi_rdata_o,
    output logic [1:0]       s_axi_rresp_o,
    output logic             s_axi_rvalid_o,
    input  wire logic        s_axi_rready_i,
    input  wire logic        timer0_rollover_i,
    input  wire logic        external_pin_event_i,
    input  wire logic        pin_change_event_i,
    input  wire logic [7:0]  periph_one_flags_i,
    input  wire logic [7:0]  periph_two_flags_i,
    input  wire logic        irq_service_i,
    input  wire logic        irq_return_i,
    output logic             irq_request_o
);
    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        WR_IDLE = 3'b001,
        WR_RESP = 3'b010,
        WR_HOLD = 3'b100
    } wr_state_e;

    typedef struct packed {
        wr_state_e   wr_state;
        logic        aw_held;
        logic        w_held;
        logic [3:0]  awaddr;
        logic [31:0] wdata;
        logic [3:0]  wstrb;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
        logic [7:0]  core_ctrl;
        logic [7:0]  pflags_one;
        logic [7:0]  pflags_two;
        logic        request;
        logic        aw_rdy;
        logic        w_rdy;
        logic        ar_rdy;
    } irq_state_s;

    irq_state_s state_ff;
    irq_state_s nxt_state;

    irq_reg_if regs_if ();

    logic       wr_fire;
    logic       wr_mapped;
    logic       rd_fire;
    logic [7:0] core_next;
    logic [7:0] pe_one;
    logic [7:0] pe_two;
    logic [7:0] hit_one;
    logic [7:0] hit_two;
    logic       periph_hit;

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    function automatic logic addr_mapped(input logic [3:0] a);
        addr_mapped = (a == irq_logic_pkg::ADDR_CORE_CTRL)
                   || (a == irq_logic_pkg::ADDR_PERIPH_ONE)
                   || (a == irq_logic_pkg::ADDR_PERIPH_TWO)
                   || (a == irq_logic_pkg::ADDR_PERIPH_FLG);
    endfunction

    // Sticky flag: event set wins over a firmware clear
    function automatic logic sticky(input logic cur,
                                    input logic wr,
                                    input logic wval,
                                    input logic evt);
        sticky = evt | (wr ? wval : cur);
    endfunction

    // ------------------------------------------------------------------
    // Peripheral enable registers
    // ------------------------------------------------------------------
    periph_enable_regs u_pe (
        .sys_clk_i (sys_clk_i),
        .arst_n_i  (arst_n_i),
        .clk_en_i  (clk_en_i),
        .regs      (regs_if.owner)
    );

    assign pe_one = regs_if.peripheral_enable_one;
    assign pe_two = regs_if.peripheral_enable_two;

    // ------------------------------------------------------------------
    // Bus and flag logic
    // ------------------------------------------------------------------
    always_comb begin
        nxt_state = state_ff;
        wr_fire   = state_ff.aw_held && state_ff.w_held
                 && state_ff.wr_state == WR_IDLE;
        wr_mapped = addr_mapped(state_ff.awaddr);
        rd_fire   = s_axi_arvalid_i && !state_ff.rvalid;
        regs_if.wr_en   = wr_fire && state_ff.wstrb[0];
        regs_if.wr_addr = state_ff.awaddr;
        regs_if.wr_data = state_ff.wdata[7:0];

        if (s_axi_awvalid_i && !state_ff.aw_held) begin
            nxt_state.aw_held = 1'b1;
            nxt_state.awaddr  = s_axi_awaddr_i;
        end
        if (s_axi_wvalid_i && !state_ff.w_held) begin
            nxt_state.w_held = 1'b1;
            nxt_state.wdata  = s_axi_wdata_i;
            nxt_state.wstrb  = s_axi_wstrb_i;
        end

        case (state_ff.wr_state)
            WR_IDLE: begin
                if (wr_fire) begin
                    nxt_state.bvalid   = 1'b1;
                    nxt_state.bresp    = wr_mapped ? irq_logic_pkg::RESP_OKAY
                                         : irq_logic_pkg::RESP_SLVERR;
                    nxt_state.wr_state = WR_RESP;
                end
            end
            WR_RESP: begin
                if (s_axi_bready_i) begin
                    nxt_state.bvalid   = 1'b0;
                    nxt_state.aw_held  = 1'b0;
                    nxt_state.w_held   = 1'b0;
                    nxt_state.wr_state = WR_HOLD;
                end
            end
            WR_HOLD: begin
                nxt_state.wr_state = WR_IDLE;
            end
            default: begin
                nxt_state.wr_state = WR_IDLE;
            end
        endcase

        // Core control: enables written, flags sticky
        core_next = state_ff.core_ctrl;
        if (regs_if.wr_en
            && state_ff.awaddr == irq_logic_pkg::ADDR_CORE_CTRL) begin
            core_next[7:3] = state_ff.wdata[7:3];
        end
        core_next[irq_logic_pkg::BIT_T0_FLAG] = sticky(
            state_ff.core_ctrl[irq_logic_pkg::BIT_T0_FLAG],
            regs_if.wr_en
                && state_ff.awaddr == irq_logic_pkg::ADDR_CORE_CTRL,
            state_ff.wdata[irq_logic_pkg::BIT_T0_FLAG],
            timer0_rollover_i); // [RULE_01] [RULE_08]
        core_next[irq_logic_pkg::BIT_EXT_FLAG] = sticky(
            state_ff.core_ctrl[irq_logic_pkg::BIT_EXT_FLAG],
            regs_if.wr_en
                && state_ff.awaddr == irq_logic_pkg::ADDR_CORE_CTRL,
            state_ff.wdata[irq_logic_pkg::BIT_EXT_FLAG],
            external_pin_event_i); // [RULE_01] [RULE_10]
        core_next[irq_logic_pkg::BIT_CHG_FLAG] = sticky(
            state_ff.core_ctrl[irq_logic_pkg::BIT_CHG_FLAG],
            regs_if.wr_en
                && state_ff.awaddr == irq_logic_pkg::ADDR_CORE_CTRL,
            state_ff.wdata[irq_logic_pkg::BIT_CHG_FLAG],
            pin_change_event_i); // [RULE_11]
        // Servicing clears global enable, return sets it
        if (irq_service_i) begin
            core_next[irq_logic_pkg::BIT_GLOBAL_EN] = 1'b0; // [RULE_23]
        end else if (irq_return_i) begin
            core_next[irq_logic_pkg::BIT_GLOBAL_EN] = 1'b1;
        end
        nxt_state.core_ctrl = core_next;

        // Peripheral flag mirror, sampled each cycle
        nxt_state.pflags_one = periph_one_flags_i
                             & irq_logic_pkg::MASK_PERIPH_ONE; // [RULE_01]
        nxt_state.pflags_two = periph_two_flags_i
                             & irq_logic_pkg::MASK_PERIPH_TWO;

        // Peripheral group: one enable-flag pair per source
        hit_one    = pe_one & nxt_state.pflags_one;
        hit_two    = pe_two & nxt_state.pflags_two;
        periph_hit = hit_one[5]                    // [RULE_12]
                  || hit_one[4]                    // [RULE_13]
                  || hit_one[3] || hit_one[2]      // [RULE_14]
                  || hit_one[1] || hit_one[0]      // [RULE_15]
                  || hit_two[7]                    // [RULE_17]
                  || hit_two[6]                    // [RULE_18]
                  || hit_two[4]                    // [RULE_19]
                  || hit_two[3]                    // [RULE_20]
                  || hit_two[2]                    // [RULE_21]
                  || hit_two[1] || hit_two[0];     // [RULE_22]

        // Request combine
        nxt_state.request =
            core_next[irq_logic_pkg::BIT_GLOBAL_EN] // [RULE_03] [RULE_24]
            && !irq_service_i
            && ((core_next[irq_logic_pkg::BIT_T0_EN]
                 && core_next[irq_logic_pkg::BIT_T0_FLAG]) // [RULE_05]
             || (core_next[irq_logic_pkg::BIT_EXT_EN]
                 && core_next[irq_logic_pkg::BIT_EXT_FLAG]) // [RULE_06]
             || (core_next[irq_logic_pkg::BIT_CHG_EN]
                 && core_next[irq_logic_pkg::BIT_CHG_FLAG]) // [RULE_07]
             || (core_next[irq_logic_pkg::BIT_PERIPH_EN] // [RULE_04]
                 && periph_hit));

        // Read channel
        if (state_ff.rvalid && s_axi_rready_i) begin
            nxt_state.rvalid = 1'b0;
        end
        if (rd_fire) begin
            nxt_state.rvalid = 1'b1;
            nxt_state.rresp  = irq_logic_pkg::RESP_OKAY;
            case (s_axi_araddr_i)
                irq_logic_pkg::ADDR_CORE_CTRL:
                    nxt_state.rdata = {24'h00_0000, state_ff.core_ctrl};
                irq_logic_pkg::ADDR_PERIPH_ONE:
                    nxt_state.rdata = {24'h00_0000, pe_one}; // [RULE_16]
                irq_logic_pkg::ADDR_PERIPH_TWO:
                    nxt_state.rdata = {24'h00_0000, pe_two}; // [RULE_16]
                irq_logic_pkg::ADDR_PERIPH_FLG:
                    nxt_state.rdata = {16'h0000, state_ff.pflags_two,
                                       state_ff.pflags_one};
                default: begin
                    nxt_state.rdata = 32'h0000_0000;
                    nxt_state.rresp = irq_logic_pkg::RESP_SLVERR;
                end
            endcase
        end

        // Ready outputs registered from the next held state
        nxt_state.aw_rdy = !nxt_state.aw_held;
        nxt_state.w_rdy  = !nxt_state.w_held;
        nxt_state.ar_rdy = !nxt_state.rvalid;
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            state_ff            <= '0;
            state_ff.wr_state   <= WR_IDLE;
            state_ff.core_ctrl  <= irq_logic_pkg::RST_CORE_CTRL; // [RULE_11]
            state_ff.aw_rdy     <= 1'b1;
            state_ff.w_rdy      <= 1'b1;
            state_ff.ar_rdy     <= 1'b1;
        end else if (clk_en_i) begin
            state_ff <= nxt_state;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign s_axi_awready_o = state_ff.aw_rdy;
    assign s_axi_wready_o  = state_ff.w_rdy;
    assign s_axi_bvalid_o  = state_ff.bvalid;
    assign s_axi_bresp_o   = state_ff.bresp;
    assign s_axi_arready_o = state_ff.ar_rdy;
    assign s_axi_rvalid_o  = state_ff.rvalid;
    assign s_axi_rdata_o   = state_ff.rdata;
    assign s_axi_rresp_o   = state_ff.rresp;
    assign irq_request_o   = state_ff.request;
endmodule

// file: bench/irq_checker_assertions.sv
// Checker of register bus handshakes and request timing
`timescale 1ns/10ps
module irq_checker (
    input wire logic        sys_clk_i,
    input wire logic        arst_n_i,
    input wire logic        s_axi_awvalid_i,
    input wire logic        s_axi_awready_o,
    input wire logic        s_axi_wvalid_i,
    input wire logic        s_axi_wready_o,
    input wire logic [1:0]  s_axi_bresp_o,
    input wire logic        s_axi_bvalid_o,
    input wire logic        s_axi_bready_i,
    input wire logic [3:0]  s_axi_araddr_i,
    input wire logic        s_axi_arvalid_i,
    input wire logic        s_axi_arready_o,
    input wire logic [31:0] s_axi_rdata_o,
    input wire logic [1:0]  s_axi_rresp_o,
    input wire logic        s_axi_rvalid_o,
    input wire logic        s_axi_rready_i,
    input wire logic        irq_service_i,
    input wire logic        irq_request_o
);
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!arst_n_i);
    // ------------------------------------------------------------------
    // Bus handshakes, read data and request drop after service
    // ------------------------------------------------------------------
    aw_take_a: assert property (s_axi_awvalid_i && s_axi_awready_o
        |=> !s_axi_awready_o) else $error("awready high after take");
    b_answer_a: assert property (s_axi_awvalid_i && s_axi_awready_o &&
        s_axi_wvalid_i && s_axi_wready_o |-> ##2 s_axi_bvalid_o)
        else $error("write response late");
    b_hold_a: assert property (s_axi_bvalid_o && !s_axi_bready_i
        |=> s_axi_bvalid_o && $stable(s_axi_bresp_o))
        else $error("write response dropped");
    r_answer_a: assert property (s_axi_arvalid_i && s_axi_arready_o
        |=> s_axi_rvalid_o) else $error("read data late");
    r_hold_a: assert property (s_axi_rvalid_o && !s_axi_rready_i
        |=> s_axi_rvalid_o && $stable(s_axi_rdata_o))
        else $error("read data dropped");
    ar_block_a: assert property (s_axi_rvalid_o |-> !s_axi_arready_o)
        else $error("arready high while read pending");
    rd_width_a: assert property (
        s_axi_rvalid_o |-> s_axi_rdata_o[31:16] == 16'h0000)
        else $error("upper read bits not zero");
    unmapped_rd_a: assert property (s_axi_arvalid_i && s_axi_arready_o
        && s_axi_araddr_i[1:0] != 2'b00 |=> s_axi_rdata_o == 32'h0 &&
        s_axi_rresp_o == irq_logic_pkg::RESP_SLVERR)
        else $error("unmapped read not refused");
    svc_drop_a: assert property (
        irq_service_i |=> !irq_request_o)
        else $error("request held after service");
endmodule

bind interrupt_enable_flag_logic irq_checker chk_u (.sys_clk_i,
    .arst_n_i, .s_axi_awvalid_i, .s_axi_awready_o, .s_axi_wvalid_i,
    .s_axi_wready_o, .s_axi_bresp_o, .s_axi_bvalid_o, .s_axi_bready_i,
    .s_axi_araddr_i, .s_axi_arvalid_i, .s_axi_arready_o, .s_axi_rdata_o,
    .s_axi_rresp_o, .s_axi_rvalid_o, .s_axi_rready_i, .irq_service_i,
    .irq_request_o);

// file: bench/core_model.sv
// Processor core model that vectors on requests and returns
`timescale 1ns/10ps
module core_model (
    input  wire logic clk_i,
    input  wire logic rst_n_i,
    input  wire logic irq_request_i,
    input  wire logic accept_i,
    input  wire logic ret_cmd_i,
    output logic      irq_service_o,
    output logic      irq_return_o
);
    logic service_ff;
    logic return_ff;
    // One service pulse per request; return on command
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            service_ff <= 1'b0;
            return_ff  <= 1'b0;
        end else begin
            service_ff <= irq_request_i && accept_i && !service_ff;
            return_ff  <= ret_cmd_i;
        end
    end
    assign irq_service_o = service_ff;
    assign irq_return_o  = return_ff;
endmodule

// file: bench/tb.sv
// Testbench of interrupt enable and flag logic
`timescale 1ns/10ps
module tb;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic [3:0]  awaddr = 4'h0, araddr = 4'h0, wstrb = 4'hF;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic        arvalid = 1'b0, rready = 1'b0;
    logic [31:0] wdata = 32'h0, rdata;
    logic        t0 = 1'b0, ext = 1'b0, chg = 1'b0;
    logic [7:0]  p1 = 8'h00, p2 = 8'h00, en, fl;
    logic        accept = 1'b0, ret = 1'b0, svc, rtn, irq_req;
    logic        ce = 1'b1;
    logic        awready, wready, bvalid, arready, rvalid;
    logic [1:0]  bresp, rresp, r, b;
    logic [31:0] d;
    logic [15:0] m;
    int          err_total = 0, n_compared = 0, cyc = 0;
    always #2 clk = ~clk;
    interrupt_enable_flag_logic dut_u (.sys_clk_i(clk), .arst_n_i(rst_n),
        .clk_en_i(ce), .s_axi_awaddr_i(awaddr),
        .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
        .s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb),
        .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready),
        .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
        .s_axi_bready_i(bready), .s_axi_araddr_i(araddr),
        .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
        .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
        .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready),
        .timer0_rollover_i(t0), .external_pin_event_i(ext),
        .pin_change_event_i(chg), .periph_one_flags_i(p1),
        .periph_two_flags_i(p2), .irq_service_i(svc),
        .irq_return_i(rtn), .irq_request_o(irq_req));
    core_model model_u (.clk_i(clk), .rst_n_i(rst_n),
        .irq_request_i(irq_req), .accept_i(accept), .ret_cmd_i(ret),
        .irq_service_o(svc), .irq_return_o(rtn));
    task automatic print_verdict();
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task automatic cmp(input string nm, input logic [31:0] e, g);
        n_compared++;
        if (g !== e) begin
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
            err_total++;
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] v,
                      input logic [3:0] s = 4'hF);
        @(posedge clk);
        awaddr <= a;
        wdata <= {24'h00_0000, v};
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge clk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        b = bresp;
        bready <= 1'b0;
    endtask
    task automatic rchk(input logic [3:0] a, input logic [31:0] e,
                        input string nm);
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge clk);
            if (arvalid && arready) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        cmp(nm, e, d);
    endtask
    task automatic ev(input logic [2:0] e);
        @(posedge clk);
        {t0, ext, chg} <= e;
        @(posedge clk);
        {t0, ext, chg} <= 3'b000;
    endtask
    task automatic req(input logic e, input string nm);
        repeat (3) @(posedge clk);
        cmp(nm, {31'h0, e}, {31'h0, irq_req});
    endtask
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 6000) begin
            err_total++;
            print_verdict();
        end
    end
    initial begin
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        rchk(4'h0, 32'h0, "core reset");
        rchk(4'h4, 32'h0, "pe1 reset");
        rchk(4'h8, 32'h0, "pe2 reset");
        wr(4'h4, 8'hFF);
        rchk(4'h4, 32'h0000_003F, "pe1 mask");
        wr(4'h8, 8'hFF);
        rchk(4'h8, 32'h0000_00DF, "pe2 mask");
        wr(4'h8, 8'h00, 4'hE);
        rchk(4'h8, 32'h0000_00DF, "strobe off");
        wr(4'h4, 8'h00);
        wr(4'h8, 8'h00);
        rchk(4'h2, 32'h0, "unmapped data");
        cmp("unmapped resp", {30'h0, irq_logic_pkg::RESP_SLVERR}, {30'h0, r});
        wr(4'h2, 8'h00);
        cmp("unmapped bresp", {30'h0, irq_logic_pkg::RESP_SLVERR},
            {30'h0, b});
        wr(4'h0, 8'h78);
        cmp("write resp", {30'h0, irq_logic_pkg::RESP_OKAY},
            {30'h0, b});
        rchk(4'h0, 32'h0000_0078, "core rw");
        wr(4'h0, 8'h00);
        @(posedge clk);
        ce <= 1'b0;
        ev(3'b100);
        ce <= 1'b1;
        rchk(4'h0, 32'h0, "frozen event lost");
        for (int j = 0; j < 3; j++) begin
            en = 8'h20 >> j;
            fl = 8'h04 >> j;
            wr(4'h0, 8'h00);
            wr(4'h0, en);
            ev(3'b100 >> j);
            req(1'b0, "req global off");
            rchk(4'h0, {24'h0, en | fl}, "flag set");
            wr(4'h0, 8'h80 | fl);
            req(1'b0, "req source off");
            wr(4'h0, 8'h80 | en | fl);
            req(1'b1, "req source on");
            @(posedge clk);
            accept <= 1'b1;
            repeat (4) @(posedge clk);
            accept <= 1'b0;
            rchk(4'h0, {24'h0, en | fl}, "service clears");
            req(1'b0, "req after service");
            ret <= 1'b1;
            @(posedge clk);
            ret <= 1'b0;
            req(1'b1, "req after return");
            wr(4'h0, 8'h00);
            rchk(4'h0, 32'h0, "flag cleared");
        end
        for (int i = 0; i < 16; i++) begin
            if (i == 6 || i == 7 || i == 13) continue;
            m = 16'h0001 << i;
            @(posedge clk);
            p1 <= m[7:0];
            p2 <= m[15:8];
            wr(4'h0, 8'hC0);
            req(1'b0, "periph enable off");
            wr(i < 8 ? 4'h4 : 4'h8, m[7:0] | m[15:8]);
            req(1'b1, "periph enable on");
            wr(4'h0, 8'h80);
            req(1'b0, "periph group off");
            rchk(4'hC, {16'h0, m}, "flag mirror");
            @(posedge clk);
            p1 <= 8'h00;
            p2 <= 8'h00;
            wr(i < 8 ? 4'h4 : 4'h8, 8'h00);
        end
        print_verdict();
    end
endmodule
